// file: common/mat_pkg.sv
package mat_pkg;
  // Timing
  localparam int CLK_PERIOD_NS     = 40;
  localparam int REFRESH_PERIOD_NS = 3400000;
  localparam int REFRESH_MAX_NS    = 4000000;
  localparam int REFRESH_CYCLES    = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  // Translation buffer layout
  localparam int          TB_LOCATIONS = 1024;
  localparam int          UB_ENTRIES   = 512;
  localparam int          CPU_ENTRIES  = 128;
  localparam int          TB_USED      = UB_ENTRIES + CPU_ENTRIES;
  localparam logic [9:0]  CPU_BASE     = 10'h200;
  localparam int          PFN_W        = 15;
  localparam int          TAG_W        = 16;
  localparam int          ACC_LSB      = 16;
  localparam int          ACC_VALID    = 0;
  localparam int          ACC_READ     = 1;
  localparam int          ACC_WRITE    = 2;
  localparam int          ACC_UB_OK    = 0;
  // Physical target decode on physical_address_bus[14:9]
  localparam logic [5:0]  ARRAY_PAGE_LIMIT = 6'h05;
  localparam logic [5:0]  UB_PAGE_SEL      = 6'h3F;
  // Register offsets
  localparam logic [7:0]  REG_CHECK_BITS = 8'h00;
  localparam logic [7:0]  REG_CPU_ERR    = 8'h04;
  localparam logic [7:0]  REG_UB_ERR     = 8'h08;
  localparam logic [7:0]  REG_TB_TAG     = 8'h0C;
  localparam logic [7:0]  REG_TB_ENTRY   = 8'h10;
  localparam logic [7:0]  REG_TB_INDEX   = 8'h14;
  // Error fields (cpu_error_control and unibus_error_status)
  localparam int ERR_MISS   = 0;
  localparam int ERR_ACCESS = 1;
  localparam int ERR_SINGLE = 2;
  localparam int ERR_MULTI  = 3;
  localparam int ERR_NXM    = 4;
  localparam int ERR_SIZE   = 5;
  localparam int ERR_W      = 6;
  localparam int CTL_ECC_OFF = 8;
  localparam int CHK_SYN_LSB = 7;
  localparam logic [ERR_W-1:0] ERR_RESET = 6'h00;
  localparam logic [31:0]      REG_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} mat_size_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_XLATE = 3'h1,
    ST_ARD   = 3'h3,
    ST_ACHK  = 3'h2,
    ST_AWR   = 3'h6,
    ST_DONE  = 3'h7
  } mat_state_t;
endpackage

// file: rtl/mat_datapath.sv
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// How it works
// [R01] CPU grant loads 32-bit address into holding register
// [R02] Bits 8:2 select longword; bits 1:0 rotate
// [R03] Buffer: 128 CPU, 512 UNIBUS, 384 unused
// [R04] Entry holds 15-bit frame plus permissions
// [R05] CPU entries keep 16-bit tag, bits 30:15
// [R06] CPU index is bit 31 with bits 14:9
// [R07] Tag mismatch flags miss and CPU summary
// [R08] Permission violation raises requester's error summary
// [R09] Frame drives physical bits; decode selects target
// [R10] Array address is frame page plus offset
// [R11] UNIBUS target gets 18-bit concatenated address
// [R12] Physical reference bypasses buffer, copies bits 23:9
// [R13] UNIBUS master loads 18-bit address
// [R14] UNIBUS index uses bits 17:9, no tag
// [R15] Refresh every 3.4 ms between array operations
// [R16] Seven check bits: fix single, flag multiple
// [R17] Read rotator brings addressed unit to bit 0
// [R18] UNIBUS gets low 16 bits; no UNIBUS longwords
// [R19] Write rotator aligns data; seven check bits generated
// [R20] Check bits register is read-only
// [R21] CPU error register writable; error bits set
// [R22] UNIBUS error register read-only, captures errors
// [R23] Grant picks CPU path, sync picks UNIBUS path
// [R24] Rotate right on reads, left on writes
module mat_datapath
  import mat_pkg::*;
#(
  parameter int REFRESH_COUNT = REFRESH_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // CPU side
  input  wire logic        cpu_grant,
  input  wire logic        cpu_start,
  input  wire logic        cpu_write,
  input  wire logic [1:0]  cpu_size,
  input  wire logic        physical_reference_flag,
  input  wire logic [31:0] controller_data_bus,
  input  wire logic [31:0] cpu_wdata,
  output logic      [31:0] cpu_rdata,
  output logic             cpu_error_summary,
  output logic             translation_miss,
  output logic             op_done,
  // UNIBUS side
  input  wire logic        ub_msync,
  input  wire logic [17:0] ub_addr,
  input  wire logic        ub_write,
  input  wire logic        ub_byte,
  input  wire logic [15:0] ub_wdata,
  output logic      [15:0] ub_rdata,
  output logic             unibus_error_summary,
  output logic             unibus_target_select,
  output logic      [17:0] unibus_address,
  output logic      [15:0] unibus_wdata,
  // Memory array side
  output logic             array_target_select,
  output logic      [14:0] physical_address_bus,
  output logic      [31:0] latched_virtual_address,
  output logic      [15:0] array_addr,
  output logic             array_rd,
  output logic             array_wr,
  output logic      [31:0] array_data_lines,
  output logic      [6:0]  array_check_out,
  input  wire logic [31:0] array_rdata,
  input  wire logic [6:0]  array_rcheck,
  output logic             refresh_req,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);

  function automatic logic [5:0] data_pos(input int i);
    logic [5:0] r;
    int         n;
    r = 6'h00;
    n = 0;
    for (int p = 3; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (n == i) r = 6'(p);
        n++;
      end
    end
    return r;
  endfunction

  // Hamming code over 38 positions plus overall parity in bit 6
  function automatic logic [6:0] ecc_gen(input logic [31:0] d);
    logic [6:0] c;
    logic [5:0] pos;
    c = 7'h00;
    for (int i = 0; i < 32; i++) begin
      pos = data_pos(i);
      for (int j = 0; j < 6; j++) if (pos[j]) c[j] = c[j] ^ d[i];
    end
    c[6] = ^{d, c[5:0]};
    return c;
  endfunction

  function automatic logic [31:0] rot_right(input logic [31:0] d, input logic [1:0] off);
    logic [5:0] sh;
    sh = {1'b0, off, 3'h0};
    return (d >> sh) | (d << (6'h20 - sh));
  endfunction

  function automatic logic [31:0] rot_left(input logic [31:0] d, input logic [1:0] off);
    logic [5:0] sh;
    sh = {1'b0, off, 3'h0};
    return (d << sh) | (d >> (6'h20 - sh));
  endfunction

  mat_state_t        state_reg;
  logic [2:0]        msync_sync;
  logic              src_cpu_reg, write_reg, phys_reg;
  logic [1:0]        size_reg;
  logic [31:0]       wdata_reg;
  logic [18:0]       tb_entry [TB_USED];
  logic [TAG_W-1:0]  tb_tag   [CPU_ENTRIES];
  logic [9:0]        tb_index_reg;
  logic [TAG_W-1:0]  tb_tag_hold_reg;
  logic [ERR_W-1:0]  cpu_err_reg, cpu_err_next, ub_err_reg, ub_err_next;
  logic [ERR_W-1:0]  xl_evt, ecc_evt;
  logic              ecc_off_reg;
  logic [12:0]       chk_stat_reg;
  logic [$clog2(REFRESH_COUNT)-1:0] refresh_cnt_reg;
  logic              refresh_pending_reg;

  // Lookup on the holding register
  logic [9:0]        idx;
  logic [18:0]       entry;
  logic [14:0]       page_frame_number;
  logic              miss, acc_bad, tgt_array, tgt_ub, xl_err;
  logic              start_cpu, start_ub;
  logic [3:0]        lane_mask;
  logic [31:0]       wr_aligned;

  assign start_cpu = (state_reg == ST_IDLE) && cpu_grant && cpu_start; // [R23]
  assign start_ub  = (state_reg == ST_IDLE) && !start_cpu && msync_sync[1] && !msync_sync[2];

  always_comb begin
    if (src_cpu_reg) begin
      idx = CPU_BASE + {3'h0, latched_virtual_address[31], latched_virtual_address[14:9]}; // [R06]
    end else begin
      idx = {1'b0, latched_virtual_address[17:9]}; // [R14]
    end
    entry = tb_entry[idx];
    page_frame_number   = phys_reg ? latched_virtual_address[23:9] : entry[PFN_W-1:0]; // [R12]
    miss  = src_cpu_reg && !phys_reg
            && (tb_tag[idx[6:0]] != latched_virtual_address[30:15]); // [R07]
    if (phys_reg) begin
      acc_bad = 1'b0;
    end else if (src_cpu_reg) begin
      acc_bad = !entry[ACC_LSB + ACC_VALID]
                || (write_reg ? !entry[ACC_LSB + ACC_WRITE] : !entry[ACC_LSB + ACC_READ]); // [R08]
    end else begin
      acc_bad = !entry[ACC_LSB + ACC_UB_OK]; // [R08]
    end
    tgt_array = page_frame_number[14:9] < ARRAY_PAGE_LIMIT; // [R09]
    tgt_ub    = src_cpu_reg && (page_frame_number[14:9] == UB_PAGE_SEL);
    xl_evt = '0;
    xl_evt[ERR_MISS]   = miss;
    xl_evt[ERR_ACCESS] = acc_bad;
    xl_evt[ERR_NXM]    = !tgt_array && !tgt_ub;
    xl_evt[ERR_SIZE]   = !src_cpu_reg && (size_reg == SZ_LONG); // [R18]
    xl_err = |xl_evt;
  end

  always_comb begin
    case (size_reg)
      SZ_BYTE: lane_mask = 4'h1;
      SZ_WORD: lane_mask = 4'h3;
      default: lane_mask = 4'hF;
    endcase
    lane_mask  = 4'((lane_mask << latched_virtual_address[1:0])
                 | (lane_mask >> (3'h4 - {1'b0, latched_virtual_address[1:0]})));
    wr_aligned = rot_left(wdata_reg, latched_virtual_address[1:0]); // [R24] [R19]
  end

  // Read check and correction
  logic [6:0]  syn_full;
  logic [5:0]  syndrome;
  logic        par_err;
  logic [31:0] rd_fixed, merged;
  always_comb begin
    syn_full = ecc_gen(array_rdata) ^ array_rcheck;
    syndrome = syn_full[5:0];
    par_err  = ^{array_rdata, array_rcheck};
    rd_fixed = array_rdata;
    for (int i = 0; i < 32; i++) begin
      if (!ecc_off_reg && par_err && (syndrome == data_pos(i))) rd_fixed[i] = !array_rdata[i]; // [R16]
    end
    ecc_evt = '0;
    ecc_evt[ERR_SINGLE] = par_err;
    ecc_evt[ERR_MULTI]  = !par_err && (syndrome != 6'h00); // [R16]
    for (int b = 0; b < 4; b++) begin
      merged[b*8 +: 8] = lane_mask[b] ? wr_aligned[b*8 +: 8] : rd_fixed[b*8 +: 8];
    end
  end

  // Pin synchroniser for master sync
  always_ff @(posedge clk) begin
    if (sys_rst) msync_sync <= 3'h0;
    else         msync_sync <= {msync_sync[1:0], ub_msync};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE:  if (start_cpu || start_ub) state_reg <= ST_XLATE;
        ST_XLATE: begin
          if (xl_err || tgt_ub) state_reg <= ST_DONE;
          else if (write_reg && size_reg == SZ_LONG) state_reg <= ST_AWR;
          else state_reg <= ST_ARD;
        end
        ST_ARD:   state_reg <= ST_ACHK;
        ST_ACHK:  state_reg <= (write_reg && !ecc_evt[ERR_MULTI]) ? ST_AWR : ST_DONE;
        ST_AWR:   state_reg <= ST_DONE;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // Request capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latched_virtual_address <= REG_RESET;
      src_cpu_reg <= 1'b0;
      write_reg   <= 1'b0;
      phys_reg    <= 1'b0;
      size_reg    <= SZ_BYTE;
      wdata_reg   <= REG_RESET;
    end else if (start_cpu) begin
      latched_virtual_address <= controller_data_bus; // [R01]
      src_cpu_reg <= 1'b1;
      write_reg   <= cpu_write;
      phys_reg    <= physical_reference_flag;
      size_reg    <= cpu_size;
      wdata_reg   <= cpu_wdata;
    end else if (start_ub) begin
      latched_virtual_address <= {14'h0000, ub_addr}; // [R13]
      src_cpu_reg <= 1'b0;
      write_reg   <= ub_write;
      phys_reg    <= 1'b0;
      size_reg    <= ub_byte ? SZ_BYTE : SZ_WORD; // [R18]
      wdata_reg   <= {16'h0000, ub_wdata};
    end
  end

  // Address outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      physical_address_bus <= 15'h0000;
      array_addr           <= 16'h0000;
      array_target_select  <= 1'b0;
      unibus_target_select <= 1'b0;
      unibus_address       <= 18'h00000;
      unibus_wdata         <= 16'h0000;
      translation_miss     <= 1'b0;
    end else if (state_reg == ST_XLATE) begin
      physical_address_bus <= page_frame_number; // [R09]
      array_addr           <= {page_frame_number[8:0], latched_virtual_address[8:2]}; // [R10] [R02]
      array_target_select  <= !xl_err && tgt_array;
      unibus_target_select <= !xl_err && tgt_ub;
      unibus_address       <= {page_frame_number[8:0], latched_virtual_address[8:0]}; // [R11]
      unibus_wdata         <= wr_aligned[15:0];
      translation_miss     <= miss;
    end else if (state_reg == ST_IDLE) begin
      array_target_select  <= 1'b0;
      unibus_target_select <= 1'b0;
      translation_miss     <= 1'b0;
    end
  end

  // Array strobes and data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      array_rd         <= 1'b0;
      array_wr         <= 1'b0;
      array_data_lines <= REG_RESET;
      array_check_out  <= 7'h00;
    end else begin
      array_rd <= (state_reg == ST_XLATE) && !xl_err && tgt_array
                  && !(write_reg && size_reg == SZ_LONG);
      array_wr <= 1'b0;
      if (state_reg == ST_XLATE && !xl_err && tgt_array && write_reg && size_reg == SZ_LONG) begin
        array_wr         <= 1'b1;
        array_data_lines <= wr_aligned; // [R19]
        array_check_out  <= ecc_gen(wr_aligned); // [R19]
      end else if (state_reg == ST_ACHK && write_reg && !ecc_evt[ERR_MULTI]) begin
        // Partial writes merge into the corrected old longword
        array_wr         <= 1'b1;
        array_data_lines <= merged;
        array_check_out  <= ecc_gen(merged);
      end
    end
  end

  // Read data and completion
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_rdata <= REG_RESET;
      ub_rdata  <= 16'h0000;
      op_done   <= 1'b0;
    end else begin
      op_done <= (state_reg == ST_XLATE && (xl_err || tgt_ub))
                 || (state_reg == ST_ACHK && !(write_reg && !ecc_evt[ERR_MULTI]))
                 || state_reg == ST_AWR;
      if (state_reg == ST_ACHK && !write_reg) begin
        if (src_cpu_reg) cpu_rdata <= rot_right(rd_fixed, latched_virtual_address[1:0]); // [R17]
        else ub_rdata <= 16'(rot_right(rd_fixed, latched_virtual_address[1:0])); // [R18]
      end
    end
  end

  // Check bits capture; software cannot write it
  always_ff @(posedge clk) begin
    if (sys_rst) chk_stat_reg <= 13'h0000;
    else if (state_reg == ST_ACHK) chk_stat_reg <= {syndrome, array_rcheck}; // [R20]
  end

  // Error registers: a new event wins over a clear in the same cycle
  always_comb begin
    logic [ERR_W-1:0] evt;
    evt = '0;
    if (state_reg == ST_XLATE) evt = xl_evt;
    else if (state_reg == ST_ACHK) evt = ecc_evt;
    cpu_err_next = cpu_err_reg;
    if (reg_wr && reg_addr == REG_CPU_ERR) cpu_err_next = cpu_err_next & ~reg_wdata[ERR_W-1:0];
    ub_err_next = ub_err_reg;
    if (reg_rd && reg_addr == REG_UB_ERR) ub_err_next = '0;
    if (src_cpu_reg) cpu_err_next = cpu_err_next | evt; // [R21]
    else ub_err_next = ub_err_next | evt; // [R22]
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_err_reg          <= ERR_RESET;
      ub_err_reg           <= ERR_RESET;
      ecc_off_reg          <= 1'b0;
      cpu_error_summary    <= 1'b0;
      unibus_error_summary <= 1'b0;
    end else begin
      cpu_err_reg          <= cpu_err_next;
      ub_err_reg           <= ub_err_next;
      cpu_error_summary    <= |cpu_err_next; // [R07] [R08] [R16]
      unibus_error_summary <= |ub_err_next; // [R08] [R16]
      if (reg_wr && reg_addr == REG_CPU_ERR) ecc_off_reg <= reg_wdata[CTL_ECC_OFF]; // [R21]
    end
  end

  // Buffer loading; the 384 unused locations ignore writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tb_index_reg    <= 10'h000;
      tb_tag_hold_reg <= 16'h0000;
    end else if (reg_wr && reg_addr == REG_TB_INDEX) begin
      tb_index_reg <= reg_wdata[9:0];
    end else if (reg_wr && reg_addr == REG_TB_TAG) begin
      tb_tag_hold_reg <= reg_wdata[TAG_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reg_wr && reg_addr == REG_TB_ENTRY && tb_index_reg < 10'(TB_USED)) begin
      tb_entry[tb_index_reg] <= reg_wdata[18:0]; // [R03] [R04]
      if (tb_index_reg >= CPU_BASE) tb_tag[tb_index_reg[6:0]] <= tb_tag_hold_reg; // [R05]
    end
  end

  // Register reads
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= REG_RESET;
    end else if (reg_rd) begin
      if (reg_addr == REG_CHECK_BITS) reg_rdata <= {19'h00000, chk_stat_reg};
      else if (reg_addr == REG_CPU_ERR) reg_rdata <= {23'h000000, ecc_off_reg, 2'h0, cpu_err_reg};
      else if (reg_addr == REG_UB_ERR) reg_rdata <= {26'h0000000, ub_err_reg};
      else if (reg_addr == REG_TB_TAG) reg_rdata <= {16'h0000, tb_tag_hold_reg};
      else if (reg_addr == REG_TB_INDEX) reg_rdata <= {22'h000000, tb_index_reg};
      else reg_rdata <= REG_RESET;
    end else begin
      reg_rdata <= REG_RESET;
    end
  end

  // Refresh only between array operations, so a long burst can delay it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refresh_cnt_reg     <= '0;
      refresh_pending_reg <= 1'b0;
      refresh_req         <= 1'b0;
    end else begin
      refresh_req <= 1'b0;
      if (refresh_cnt_reg == ($clog2(REFRESH_COUNT))'(REFRESH_COUNT - 1)) begin
        refresh_cnt_reg     <= '0;
        refresh_pending_reg <= 1'b1; // [R15]
      end else begin
        refresh_cnt_reg <= refresh_cnt_reg + 1'b1;
        if (refresh_pending_reg && state_reg == ST_IDLE && !start_cpu && !start_ub) begin
          refresh_pending_reg <= 1'b0;
          refresh_req         <= 1'b1; // [R15]
        end
      end
    end
  end

  property p_var_cpu;
    @(posedge clk) disable iff (sys_rst)
      start_cpu |=> latched_virtual_address == $past(controller_data_bus) && src_cpu_reg;
  endproperty
  a_var_cpu: assert property (p_var_cpu) else $error("cpu address not latched"); // [R01]

  property p_var_ub;
    @(posedge clk) disable iff (sys_rst)
      start_ub |=> latched_virtual_address == {14'h0000, $past(ub_addr)} && !src_cpu_reg;
  endproperty
  a_var_ub: assert property (p_var_ub) else $error("unibus address not latched"); // [R13]

  property p_miss;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == ST_XLATE && miss) |=> translation_miss && cpu_error_summary;
  endproperty
  a_miss: assert property (p_miss) else $error("miss did not raise summary"); // [R07]

  property p_ub_no_tag;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == ST_XLATE && !src_cpu_reg) |=> !translation_miss;
  endproperty
  a_ub_no_tag: assert property (p_ub_no_tag) else $error("unibus lookup flagged miss"); // [R14]

  property p_bypass;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == ST_XLATE && phys_reg) |=> physical_address_bus == $past(latched_virtual_address[23:9]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("physical bypass wrong"); // [R12]

  property p_array_addr;
    @(posedge clk) disable iff (sys_rst)
      $rose(array_rd) |-> array_addr == {physical_address_bus[8:0], latched_virtual_address[8:2]}
                          && array_target_select;
  endproperty
  a_array_addr: assert property (p_array_addr) else $error("array address wrong"); // [R10]

  property p_ub_addr;
    @(posedge clk) disable iff (sys_rst)
      $rose(unibus_target_select) |-> unibus_address[17:9] == physical_address_bus[8:0]
                                      && unibus_address[8:0] == latched_virtual_address[8:0];
  endproperty
  a_ub_addr: assert property (p_ub_addr) else $error("unibus address wrong"); // [R11]

  property p_read_done;
    @(posedge clk) disable iff (sys_rst)
      (array_rd && !write_reg) |=> ##1 op_done;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read did not complete"); // [R16]

  property p_chk_ro;
    @(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == REG_CHECK_BITS && state_reg != ST_ACHK) |=> $stable(chk_stat_reg);
  endproperty
  a_chk_ro: assert property (p_chk_ro) else $error("check bits register written"); // [R20]

endmodule

// file: testbench/mat_array_model.sv
`timescale 1ns/1ps
module mat_array_model (
  // Clock
  input  wire logic        clk,
  // Array port
  input  wire logic        array_rd,
  input  wire logic        array_wr,
  input  wire logic [15:0] array_addr,
  input  wire logic [31:0] array_data_lines,
  input  wire logic [6:0]  array_check_out,
  // Error injection on read answers
  input  wire logic [38:0] corrupt,
  output logic      [31:0] array_rdata = 32'h0,
  output logic      [6:0]  array_rcheck = 7'h0
);
  logic [38:0] mem [logic [15:0]];
  always @(posedge clk) begin
    if (array_wr) begin
      mem[array_addr] = {array_check_out, array_data_lines};
    end
    // Answer stands one cycle; otherwise toggle so stale data never matches
    if (array_rd) begin
      {array_rcheck, array_rdata} <= corrupt
        ^ (mem.exists(array_addr) ? mem[array_addr] : 39'h0);
    end else begin
      {array_rcheck, array_rdata} <= ~{array_rcheck, array_rdata};
    end
  end
endmodule

// file: testbench/tb_mat_datapath.sv
`timescale 1ns/1ps
module tb_mat_datapath import mat_pkg::*; ;
  logic        clk = 1'b0, sys_rst = 1'b1, cpu_grant = 1'b0, cpu_start = 1'b0;
  logic        cpu_write = 1'b0, physical_reference_flag = 1'b0, ub_msync = 1'b0;
  logic        ub_write = 1'b0, ub_byte = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0]  cpu_size = 2'h0;
  logic [31:0] controller_data_bus = 32'h0, cpu_wdata = 32'h0, reg_wdata = 32'h0;
  logic [17:0] ub_addr = 18'h0;
  logic [15:0] ub_wdata = 16'h0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] cpu_rdata, latched_virtual_address, array_data_lines, array_rdata, reg_rdata;
  logic        cpu_error_summary, translation_miss, op_done, unibus_error_summary;
  logic        unibus_target_select, array_target_select, array_rd, array_wr, refresh_req;
  logic [15:0] ub_rdata, unibus_wdata, array_addr, wa_seen;
  logic [17:0] unibus_address;
  logic [14:0] physical_address_bus;
  logic [6:0]  array_check_out, array_rcheck;
  logic [31:0] wr_seen;
  logic [38:0] corrupt = 39'h0;
  int          n_errors = 0, check_count = 0, lat, k;

  always #20 clk = ~clk;
  mat_datapath #(.REFRESH_COUNT(20)) dut (.*);
  mat_array_model mem (.clk, .array_rd, .array_wr, .array_addr, .array_data_lines,
                       .array_check_out, .array_rdata, .array_rcheck, .corrupt);
  always @(posedge clk) if (array_wr) begin
    wr_seen <= array_data_lines;
    wa_seen <= array_addr;
  end

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rw(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string n);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask
  task automatic wait_done;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      #1 lat = i + 1;
      if (op_done === 1'b1) return;
    end
    chk("op_done", 0, 1);
  endtask
  task automatic cpu(logic [31:0] va, logic w, logic [1:0] sz, logic ph, logic [31:0] wd);
    @(posedge clk);
    cpu_start <= 1'b1; controller_data_bus <= va; cpu_write <= w; cpu_size <= sz;
    physical_reference_flag <= ph; cpu_wdata <= wd;
    @(posedge clk);
    cpu_start <= 1'b0;
    wait_done;
  endtask
  task automatic ub(logic [17:0] a, logic w, logic [15:0] d, logic by);
    @(posedge clk);
    cpu_grant <= 1'b0; ub_addr <= a; ub_write <= w; ub_wdata <= d;
    ub_byte <= by;
    // Address held three cycles ahead of the synchroniser
    repeat (3) @(posedge clk);
    ub_msync <= 1'b1;
    wait_done;
    @(posedge clk);
    ub_msync <= 1'b0;
    repeat (4) @(posedge clk);
    cpu_grant <= 1'b1;
  endtask

  task automatic t_regs;
    rd(REG_CHECK_BITS, 0, "chk_bits");
    rd(REG_CPU_ERR, 0, "cpu_err");
    rd(REG_UB_ERR, 0, "ub_err");
    rw(REG_CHECK_BITS, 32'hFFFF_FFFF);
    rd(REG_CHECK_BITS, 0, "chk_ro");
    rd(8'h3C, 0, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_cpu;
    rw(REG_TB_TAG, 32'h3);
    rw(REG_TB_INDEX, 32'h205);
    rw(REG_TB_ENTRY, 32'h0007_0007);
    cpu(32'h0001_8A40, 1, SZ_LONG, 0, 32'hA1B2_C3D4);
    chk("lat_w", lat, 2);
    chk("wdata", wr_seen, 32'hA1B2_C3D4);
    chk("aaddr", wa_seen, 16'h0390);
    chk("pa", physical_address_bus, 15'h0007);
    chk("asel", array_target_select, 1);
    chk("lva", latched_virtual_address, 32'h0001_8A40);
    cpu(32'h0001_8A41, 0, SZ_BYTE, 0, 0);
    chk("lat_r", lat, 3);
    chk("byte", cpu_rdata[7:0], 8'hC3);
    cpu(32'h0001_8A42, 0, SZ_WORD, 0, 0);
    chk("word", cpu_rdata[15:0], 16'hA1B2);
    cpu(32'h0001_8A43, 1, SZ_BYTE, 0, 32'h0000_00EE);
    chk("lat_p", lat, 4);
    chk("wbyte", wr_seen, 32'hEEB2_C3D4);
    $display("test cpu done");
  endtask
  task automatic t_miss;
    cpu(32'h0001_0A40, 0, SZ_LONG, 0, 0);
    chk("miss", translation_miss, 1);
    chk("sum", cpu_error_summary, 1);
    rd(REG_CPU_ERR, 32'h1, "err_miss");
    rw(REG_CPU_ERR, 32'h101);
    rd(REG_CPU_ERR, 32'h100, "err_ctl");
    rw(REG_CPU_ERR, 0);
    #1 chk("sum_clr", cpu_error_summary, 0);
    $display("test miss done");
  endtask
  task automatic t_phys;
    cpu(32'h0000_0E40, 0, SZ_LONG, 1, 0);
    chk("pdata", cpu_rdata, 32'hEEB2_C3D4);
    chk("ppa", physical_address_bus, 15'h0007);
    chk("paddr", array_addr, 16'h0390);
    $display("test phys done");
  endtask
  task automatic t_ub;
    rw(REG_TB_INDEX, 32'h3);
    rw(REG_TB_ENTRY, 32'h0001_0007);
    rw(REG_TB_INDEX, 32'h4);
    rw(REG_TB_ENTRY, 32'h0000_0007);
    ub(18'h00642, 0, 0, 0);
    chk("ubrd", ub_rdata, 16'hEEB2);
    chk("ublva", latched_virtual_address[17:0], 18'h00642);
    ub(18'h00640, 1, 16'h1234, 0);
    chk("ubwr", wr_seen, 32'hEEB2_1234);
    ub(18'h00643, 0, 0, 1);
    chk("ubbyte", ub_rdata[7:0], 8'hEE);
    ub(18'h00800, 0, 0, 0);
    chk("ubsum", unibus_error_summary, 1);
    rd(REG_UB_ERR, 32'h2, "ub_acc");
    rd(REG_UB_ERR, 0, "ub_clr");
    $display("test unibus done");
  endtask
  task automatic t_xub;
    rw(REG_TB_TAG, 32'h0);
    rw(REG_TB_INDEX, 32'h206);
    rw(REG_TB_ENTRY, 32'h0007_7E07);
    cpu(32'h0000_0C85, 1, SZ_BYTE, 0, 32'h0000_00AB);
    chk("lat_u", lat, 1);
    chk("usel", unibus_target_select, 1);
    chk("asel0", array_target_select, 0);
    chk("uaddr", unibus_address, 18'h00E85);
    chk("uwdata", unibus_wdata, 16'hAB00);
    chk("upa", physical_address_bus, 15'h7E07);
    rw(REG_TB_ENTRY, 32'h0007_2007);
    cpu(32'h0000_0C85, 0, SZ_BYTE, 0, 0);
    rd(REG_CPU_ERR, 32'h10, "err_nxm");
    rw(REG_CPU_ERR, 32'h10);
    $display("test target done");
  endtask
  task automatic t_ecc;
    @(posedge clk);
    corrupt <= 39'h1;
    cpu(32'h0001_8A40, 0, SZ_LONG, 0, 0);
    chk("fix", cpu_rdata, 32'hEEB2_1234);
    chk("sum_ecc", cpu_error_summary, 1);
    rd(REG_CPU_ERR, 32'h4, "err_single");
    rw(REG_CPU_ERR, 32'h4);
    corrupt <= 39'h3;
    cpu(32'h0001_8A40, 0, SZ_LONG, 0, 0);
    rd(REG_CPU_ERR, 32'h8, "err_multi");
    rw(REG_CPU_ERR, 32'h8);
    corrupt <= 39'h0;
    $display("test ecc done");
  endtask
  task automatic t_refresh;
    k = 0;
    repeat (45) begin
      @(posedge clk);
      #1 k += (refresh_req === 1'b1);
    end
    chk("refresh", k >= 2, 1);
    $display("test refresh done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    cpu_grant <= 1'b1;
    t_regs;
    t_cpu;
    t_miss;
    t_phys;
    t_ub;
    t_xub;
    t_ecc;
    t_refresh;
    final_report;
  end
  initial begin
    #400000;
    n_errors++;
    final_report;
  end
endmodule
